// file: rtl/page_stretch_regs.vh
// constants for the page-mode stretched external data transfer timer
// assumes one system clock domain; all counts are in system clocks
//
// Overview of operation
// - stretch codes map 0-3 and 7-10 cycles
// - code zero adds no stretch at all
// - codes 1-3 add exactly that many cycles
// - code 1: one clock setup, one hold
// - codes 4-7: two cycles setup, one hold
// - codes 4-7 widen latch strobe on miss
// - page hit completes sooner than miss
// - timing 11 behaves like non-page mode
// - timing 01 strobes 1,3,7..27 oscillator clocks
// - timing 10 strobes 2,4,8..28 oscillator clocks
// - strobe width scales with clock setting
// - each stretch cycle is four clocks
// - miss when upper address byte changes
// - miss pulses latch strobe, strobes idle
`ifndef PAGE_STRETCH_REGS_VH
`define PAGE_STRETCH_REGS_VH

// ************************************************
// encodings
// ************************************************
`define PTS_ONE_CYC      2'b00
`define PTS_TWO_CYC      2'b01
`define PTS_FOUR_CYC     2'b10
`define PTS_NONPAGE      2'b11
`define DIV_BY_ONE       2'b10
`define DIV_SLOWEST      2'b11
`define DIV_FAST         2'b00
`define SLOW_CODE_BIT    2

// ************************************************
// timing counts in system clocks
// ************************************************
`define STRETCH_CYC_CLKS 6'h04
`define SLOW_CYC_OFS     4'h3
`define HIT_LEN_ONE      6'h01
`define HIT_LEN_TWO      6'h02
`define HIT_LEN_FOUR     6'h04
`define STB_BASE_ONE     6'h01
`define STB_BASE_TWO     6'h02
`define FIRST_SETUP      6'h01
`define FIRST_HOLD       6'h01
`define SLOW_SETUP       6'h08
`define SLOW_HOLD        6'h04
`define STB_EXTRA_ADJ    6'h02
`define LEN_ZERO         6'h00
`define LEN_ONE          6'h01

// ************************************************
// oscillator quarter-clock scaling shifts
// ************************************************
`define SHIFT_MULT4      4'h0
`define SHIFT_MULT2      4'h1
`define SHIFT_DIV1       4'h2
`define SHIFT_DIV1024    4'hc

// ************************************************
// reset values
// ************************************************
`define RST_BYTE         8'h00
`define RST_WIDTH        17'h00000
`define RST_STRETCH      4'h0
`define RST_LEN          6'h00

`endif

// file: rtl/stretch_decode.v
// decodes a stretch code into phase lengths for one external data transfer
// assumes purely combinational use by the transfer sequencer
`include "page_stretch_regs.vh"

module stretch_decode (
  input  wire [2:0] code,
  output reg  [3:0] stretch_cycles,
  output reg  [5:0] setup_extra,
  output reg  [5:0] hold_extra,
  output reg  [5:0] strobe_extra,
  output reg  [5:0] ale_extra
);

  always @*
  begin
    stretch_cycles = `RST_STRETCH;
    setup_extra    = `LEN_ZERO;
    hold_extra     = `LEN_ZERO;
    strobe_extra   = `LEN_ZERO;
    ale_extra      = `LEN_ZERO;
    if (code[`SLOW_CODE_BIT])
    begin
      // slow group: 7..10 cycles, 3 spent outside the strobe
      stretch_cycles = {1'b0, code} + `SLOW_CYC_OFS;
      setup_extra    = `SLOW_SETUP;
      hold_extra     = `SLOW_HOLD;
      ale_extra      = `STRETCH_CYC_CLKS;
      strobe_extra   = ({3'b000, code} * `STRETCH_CYC_CLKS) - `STB_EXTRA_ADJ;
    end
    else if (code != 3'b000)
    begin
      stretch_cycles = {1'b0, code};
      setup_extra    = `FIRST_SETUP;
      hold_extra     = `FIRST_HOLD;
      // four clocks per stretch cycle, two of them lent to setup and hold
      strobe_extra   = ({3'b000, code} * `STRETCH_CYC_CLKS) - `STB_EXTRA_ADJ;
    end
  end

endmodule

// file: rtl/page_mode_data_stretch.v
// sequencer for one stretched external data transfer in page mode
// assumes clk_sys is the system clock and the core holds request inputs stable while idle
`include "page_stretch_regs.vh"

module page_mode_data_stretch (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        xfer_req,
  input  wire        xfer_write,
  input  wire [15:0] xfer_addr,
  input  wire [2:0]  data_stretch_sel,
  input  wire [1:0]  page_timing_sel,
  input  wire        page_mode_en,
  input  wire        clock_multiplier_sel,
  input  wire [1:0]  clock_divide_sel,
  output reg         busy_q,
  output reg         done_q,
  output reg         ale_q,
  output reg         rd_n_q,
  output reg         wr_n_q,
  output reg  [7:0]  addr_bus_q,
  output reg         page_miss_q,
  output reg  [3:0]  stretch_cycles_q,
  output reg  [16:0] strobe_quarters_q
);

  // ************************************************
  // states
  // ************************************************
  localparam [5:0] S_IDLE   = 6'b000001;
  localparam [5:0] S_ALE    = 6'b000010;
  localparam [5:0] S_SETUP  = 6'b000100;
  localparam [5:0] S_STROBE = 6'b001000;
  localparam [5:0] S_HOLD   = 6'b010000;
  localparam [5:0] S_DONE   = 6'b100000;

  reg  [5:0] state_q;
  reg  [5:0] state_d;
  reg  [5:0] cnt_q;
  reg  [5:0] cnt_d;
  reg  [5:0] setup_len_q;
  reg  [5:0] strobe_len_q;
  reg  [5:0] hold_len_q;
  reg  [7:0] page_q;
  reg        page_valid_q;
  reg        write_q;
  reg  [7:0] low_q;
  reg  [7:0] high_q;

  wire [3:0] dec_stretch;
  wire [5:0] dec_setup;
  wire [5:0] dec_hold;
  wire [5:0] dec_strobe;
  wire [5:0] dec_ale;

  // ************************************************
  // stretch decode
  // ************************************************
  stretch_decode u_decode (
    .code           (data_stretch_sel),
    .stretch_cycles (dec_stretch),
    .setup_extra    (dec_setup),
    .hold_extra     (dec_hold),
    .strobe_extra   (dec_strobe),
    .ale_extra      (dec_ale)
  );

  // ************************************************
  // base cycle per page timing
  // ************************************************
  reg  [1:0] eff_timing;
  reg  [5:0] hit_len;
  reg  [5:0] stb_base;
  reg        force_miss;

  always @*
  begin
    // page mode off runs the same bus cycle as timing 11
    eff_timing = page_mode_en ? page_timing_sel : `PTS_NONPAGE;
    force_miss = 1'b0;
    case (eff_timing)
      `PTS_ONE_CYC:
      begin
        hit_len  = `HIT_LEN_ONE;
        stb_base = `STB_BASE_ONE;
        // one-cycle page mode forces a miss on every data move
        force_miss = 1'b1;
      end
      `PTS_TWO_CYC:
      begin
        hit_len  = `HIT_LEN_TWO;
        stb_base = `STB_BASE_ONE;
      end
      `PTS_FOUR_CYC:
      begin
        hit_len  = `HIT_LEN_FOUR;
        stb_base = `STB_BASE_TWO;
      end
      default:
      begin
        // four-clock data cycle, address phase every time
        hit_len    = `HIT_LEN_TWO;
        stb_base   = `STB_BASE_TWO;
        force_miss = 1'b1;
      end
    endcase
  end

  // ************************************************
  // page compare
  // ************************************************
  wire miss_now = force_miss | ~page_valid_q | (xfer_addr[15:8] != page_q);
  wire start    = (state_q == S_IDLE) & xfer_req;

  // ************************************************
  // clock-setting scale for the reported strobe width
  // ************************************************
  reg  [3:0]  scale_shift;
  wire [5:0]  strobe_len_d = stb_base + dec_strobe;
  wire [16:0] strobe_scaled = {11'h000, strobe_len_d} << scale_shift;

  always @*
  begin
    // width in oscillator quarter clocks; one system clock is 1, 2, 4 or 4096 of them by setting
    if (clock_divide_sel == `DIV_SLOWEST)
      scale_shift = `SHIFT_DIV1024;
    else if (clock_divide_sel == `DIV_FAST)
      scale_shift = clock_multiplier_sel ? `SHIFT_MULT4 : `SHIFT_MULT2;
    else
      scale_shift = `SHIFT_DIV1;
  end

  // ************************************************
  // sequencer
  // ************************************************
  always @*
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      S_IDLE:
      begin
        if (xfer_req)
        begin
          if (miss_now)
          begin
            state_d = S_ALE;
            cnt_d   = hit_len + (dec_ale - `LEN_ONE);
          end
          else if ((hit_len - stb_base) + dec_setup != `LEN_ZERO)
          begin
            // hit skips the latch phase, hence shorter than a miss
            state_d = S_SETUP;
            cnt_d   = (hit_len - stb_base) + dec_setup - `LEN_ONE;
          end
          else
          begin
            state_d = S_STROBE;
            cnt_d   = strobe_len_d - `LEN_ONE;
          end
        end
      end
      S_ALE:
      begin
        if (cnt_q == `LEN_ZERO)
        begin
          if (setup_len_q != `LEN_ZERO)
          begin
            state_d = S_SETUP;
            cnt_d   = setup_len_q - `LEN_ONE;
          end
          else
          begin
            state_d = S_STROBE;
            cnt_d   = strobe_len_q - `LEN_ONE;
          end
        end
        else
          cnt_d = cnt_q - `LEN_ONE;
      end
      S_SETUP:
      begin
        if (cnt_q == `LEN_ZERO)
        begin
          state_d = S_STROBE;
          cnt_d   = strobe_len_q - `LEN_ONE;
        end
        else
          cnt_d = cnt_q - `LEN_ONE;
      end
      S_STROBE:
      begin
        if (cnt_q == `LEN_ZERO)
        begin
          if (hold_len_q != `LEN_ZERO)
          begin
            state_d = S_HOLD;
            cnt_d   = hold_len_q - `LEN_ONE;
          end
          else
            state_d = S_DONE;
        end
        else
          cnt_d = cnt_q - `LEN_ONE;
      end
      S_HOLD:
      begin
        if (cnt_q == `LEN_ZERO)
          state_d = S_DONE;
        else
          cnt_d = cnt_q - `LEN_ONE;
      end
      S_DONE:
        state_d = S_IDLE;
      default:
      begin
        state_d = S_IDLE;
        cnt_d   = `LEN_ZERO;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      cnt_q   <= `RST_LEN;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ************************************************
  // per-transfer capture
  // ************************************************
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setup_len_q       <= `RST_LEN;
      strobe_len_q      <= `RST_LEN;
      hold_len_q        <= `RST_LEN;
      write_q           <= 1'b0;
      low_q             <= `RST_BYTE;
      high_q            <= `RST_BYTE;
      page_q            <= `RST_BYTE;
      page_valid_q      <= 1'b0;
      page_miss_q       <= 1'b0;
      stretch_cycles_q  <= `RST_STRETCH;
      strobe_quarters_q <= `RST_WIDTH;
    end
    else if (start)
    begin
      // code is sampled once here and not looked at again until idle
      setup_len_q       <= (hit_len - stb_base) + dec_setup;
      strobe_len_q      <= strobe_len_d;
      hold_len_q        <= dec_hold;
      write_q           <= xfer_write;
      low_q             <= xfer_addr[7:0];
      high_q            <= xfer_addr[15:8];
      page_q            <= xfer_addr[15:8];
      page_valid_q      <= 1'b1;
      page_miss_q       <= miss_now;
      stretch_cycles_q  <= dec_stretch;
      strobe_quarters_q <= strobe_scaled;
    end
  end

  // ************************************************
  // bus outputs, registered from next state
  // ************************************************
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      ale_q      <= 1'b0;
      rd_n_q     <= 1'b1;
      wr_n_q     <= 1'b1;
      addr_bus_q <= `RST_BYTE;
    end
    else
    begin
      busy_q <= (state_d != S_IDLE);
      done_q <= (state_d == S_DONE);
      // latch strobe only with the upper byte out, strobes kept idle
      ale_q  <= (state_d == S_ALE);
      rd_n_q <= ~((state_d == S_STROBE) & ~(start ? xfer_write : write_q));
      wr_n_q <= ~((state_d == S_STROBE) & (start ? xfer_write : write_q));
      if (state_d == S_ALE)
        addr_bus_q <= start ? xfer_addr[15:8] : high_q;
      else if (state_d != S_IDLE)
        addr_bus_q <= start ? xfer_addr[7:0] : low_q;
    end
  end

endmodule

// file: test/ext_latch_ram.sv
// far-side model: external address latch and a capture of the low address byte
// assumes the sequencer drives the latch strobe and both strobes
module ext_latch_ram (
  input  logic       ale_q,
  input  logic       rd_n_q,
  input  logic       wr_n_q,
  input  logic [7:0] addr_bus_q,
  output logic [7:0] hi_latched,
  output logic [7:0] lo_seen
);
  timeunit 1ns;
  timeprecision 100ps;

  // transparent latch, as a real one: it closes when the strobe falls
  always_latch
  begin
    if (ale_q)
      hi_latched <= addr_bus_q;
  end

  // low byte taken as a strobe opens, the earliest a part may look
  always @(negedge (rd_n_q & wr_n_q))
    lo_seen <= addr_bus_q;
endmodule

// file: test/page_mode_data_stretch_props.sv
// assertions on the stretched transfer sequencer ports
// assumes timing selections stay steady while a transfer runs
module stretch_checker (
  input logic        clk_sys,
  input logic        rst_n,
  input logic        xfer_req,
  input logic        xfer_write,
  input logic [15:0] xfer_addr,
  input logic [2:0]  data_stretch_sel,
  input logic [1:0]  page_timing_sel,
  input logic        page_mode_en,
  input logic        clock_multiplier_sel,
  input logic [1:0]  clock_divide_sel,
  input logic        busy_q,
  input logic        done_q,
  input logic        ale_q,
  input logic        rd_n_q,
  input logic        wr_n_q,
  input logic [7:0]  addr_bus_q,
  input logic        page_miss_q,
  input logic [3:0]  stretch_cycles_q,
  input logic [16:0] strobe_quarters_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] low_q;
  logic [2:0] code;
  logic [5:0] w_exp;

  function automatic logic [3:0] dec(input logic [2:0] c);
    return c[2] ? 4'(c) + 4'h3 : 4'(c);
  endfunction

  // *****************
  // strobe length
  // *****************
  assign code  = stretch_cycles_q > 4'h3 ? 3'(stretch_cycles_q - 4'h3) : stretch_cycles_q[2:0];
  assign w_exp = ((!page_mode_en || page_timing_sel[1]) ? 6'h02 : 6'h01)
               + ((code != 3'h0) ? 6'({code, 2'b00}) - 6'h02 : 6'h00);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      low_q <= 6'h00;
    else if (rd_n_q && wr_n_q)
      low_q <= 6'h00;
    else
      low_q <= low_q + 6'h01;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // *****************
  // properties
  // *****************
  latch_idle_a: assert property (ale_q |-> rd_n_q && wr_n_q && busy_q)
    else $error("strobe active in latch phase");
  done_end_a: assert property (done_q |-> busy_q ##1 !busy_q && !done_q)
    else $error("done not a single closing cycle");
  decode_start_a: assert property ($rose(busy_q) |-> stretch_cycles_q == dec($past(data_stretch_sel)))
    else $error("stretch count wrong at start");
  code_hold_a: assert property (busy_q && $past(busy_q) |-> $stable(stretch_cycles_q))
    else $error("stretch count moved mid transfer");
  strobe_len_a: assert property ($rose(rd_n_q && wr_n_q) |-> low_q == w_exp)
    else $error("strobe width wrong");
  miss_latch_a: assert property ($rose(busy_q) |-> ale_q == page_miss_q)
    else $error("latch phase disagrees with miss");
  forced_miss_a: assert property ($rose(busy_q) &&
    (!$past(page_mode_en) || $past(page_timing_sel) == 2'b11 || $past(page_timing_sel) == 2'b00) |-> page_miss_q)
    else $error("forced miss missing");
  hold_bound_a: assert property ($rose(rd_n_q && wr_n_q) |-> ##[0:4] done_q)
    else $error("hold phase too long");
endmodule

bind page_mode_data_stretch stretch_checker u_stretch_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .xfer_req(xfer_req), .xfer_write(xfer_write), .xfer_addr(xfer_addr),
  .data_stretch_sel(data_stretch_sel), .page_timing_sel(page_timing_sel), .page_mode_en(page_mode_en),
  .clock_multiplier_sel(clock_multiplier_sel), .clock_divide_sel(clock_divide_sel), .busy_q(busy_q),
  .done_q(done_q), .ale_q(ale_q), .rd_n_q(rd_n_q), .wr_n_q(wr_n_q), .addr_bus_q(addr_bus_q),
  .page_miss_q(page_miss_q), .stretch_cycles_q(stretch_cycles_q), .strobe_quarters_q(strobe_quarters_q));

// file: test/page_mode_data_stretch_bench.sv
// self-checking bench for the stretched external transfer sequencer
// assumes the latch model and the bound checker sit beside the design
module page_mode_data_stretch_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys, rst_n, xfer_req, xfer_write, page_mode_en, clock_multiplier_sel;
  logic [15:0] xfer_addr;
  logic [2:0]  data_stretch_sel;
  logic [1:0]  page_timing_sel, clock_divide_sel;
  logic        busy_q, done_q, ale_q, rd_n_q, wr_n_q, page_miss_q, page_ok;
  logic [7:0]  addr_bus_q, hi_latched, lo_seen, prev_hi;
  logic [3:0]  stretch_cycles_q;
  logic [16:0] strobe_quarters_q;
  int          err_total, compares, cycles;

  page_mode_data_stretch u_page_mode_data_stretch (
    .clk_sys(clk_sys), .rst_n(rst_n), .xfer_req(xfer_req), .xfer_write(xfer_write), .xfer_addr(xfer_addr),
    .data_stretch_sel(data_stretch_sel), .page_timing_sel(page_timing_sel), .page_mode_en(page_mode_en),
    .clock_multiplier_sel(clock_multiplier_sel), .clock_divide_sel(clock_divide_sel), .busy_q(busy_q),
    .done_q(done_q), .ale_q(ale_q), .rd_n_q(rd_n_q), .wr_n_q(wr_n_q), .addr_bus_q(addr_bus_q),
    .page_miss_q(page_miss_q), .stretch_cycles_q(stretch_cycles_q), .strobe_quarters_q(strobe_quarters_q));
  ext_latch_ram u_ext_latch_ram (.ale_q(ale_q), .rd_n_q(rd_n_q), .wr_n_q(wr_n_q), .addr_bus_q(addr_bus_q),
    .hi_latched(hi_latched), .lo_seen(lo_seen));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // a hung handshake ends here rather than running forever
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  task conclude;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one transfer; the code is scrambled and a request repeated while busy
  task automatic xfer(input logic w, input logic [15:0] a, input logic [2:0] c, input logic [1:0] t,
                      input logic en, input logic [2:0] cs, output int n);
    int   hl, bs, wv, sv, hv, av, na, ns, bad, q;
    logic miss;
    hl = (!en || t == 2'b11) ? 2 : (t == 2'b00) ? 1 : (t == 2'b01) ? 2 : 4;
    bs = (!en || t[1]) ? 2 : 1;
    wv = bs + ((c != 0) ? 4 * c - 2 : 0);
    sv = hl - bs + ((c == 0) ? 0 : (c < 4) ? 1 : 8);
    hv = (c == 0) ? 0 : (c < 4) ? 1 : 4;
    miss = !page_ok || !en || t == 2'b00 || t == 2'b11 || a[15:8] != prev_hi;
    av = miss ? hl + (c[2] ? 4 : 0) : 0;
    q = (cs[1:0] == 2'b11) ? wv * 4096 : (cs[1:0] == 2'b00) ? (cs[2] ? wv : wv * 2) : wv * 4;
    @(negedge clk_sys);
    {xfer_write, xfer_addr, data_stretch_sel, page_timing_sel, page_mode_en} = {w, a, c, t, en};
    {clock_multiplier_sel, clock_divide_sel} = cs;
    xfer_req = 1'b1;
    n = 0;
    na = 0;
    ns = 0;
    bad = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
      if (n == 1)
        data_stretch_sel = ~c;
      if (n == 2)
        xfer_req = 1'b0;
      na += ale_q;
      ns += w ? !wr_n_q : !rd_n_q;
      bad += w ? !rd_n_q : !wr_n_q;
    end
    while (done_q !== 1'b1 && n < 80);
    data_stretch_sel = c;
    chk("cycles", 17'(av + sv + wv + hv + 1), 17'(n));
    chk("latch cycles", 17'(av), 17'(na));
    chk("strobe cycles", 17'(wv), 17'(ns));
    chk("other strobe", 17'h0, 17'(bad));
    chk("page miss", 17'(miss), 17'(page_miss_q));
    chk("stretch", 17'(c[2] ? c + 3 : c), 17'(stretch_cycles_q));
    chk("quarters", 17'(q), strobe_quarters_q);
    chk("latched page", 17'(a[15:8]), 17'(hi_latched));
    chk("low byte", 17'(a[7:0]), 17'(lo_seen));
    prev_hi = a[15:8];
    page_ok = 1'b1;
  endtask

  task sc_codes(input logic [1:0] t);
    int n;
    xfer(1'b0, {6'h15, t, 8'h00}, 3'h0, t, 1'b1, 3'b010, n);
    for (int c = 0; c < 8; c++)
      xfer(c[0], {6'h15, t, 5'(c), 3'h3}, 3'(c), t, 1'b1, 3'b010, n);
  endtask

  task sc_miss_hit;
    int nm, nh;
    xfer(1'b0, 16'h5510, 3'h4, 2'b01, 1'b1, 3'b010, nm);
    xfer(1'b1, 16'h5520, 3'h4, 2'b01, 1'b1, 3'b010, nh);
    chk("hit shorter", 17'h1, 17'(nh < nm));
    xfer(1'b0, 16'h6630, 3'h7, 2'b10, 1'b1, 3'b010, nm);
    xfer(1'b0, 16'h5540, 3'h7, 2'b10, 1'b1, 3'b010, nm);
  endtask

  task sc_forced;
    int n;
    for (int i = 0; i < 6; i++)
      xfer(i[0], 16'h7700 + 16'(i), 3'(i + 1), (i < 2) ? 2'b00 : (i < 4) ? 2'b11 : 2'b01, i < 4, 3'b010, n);
  endtask

  task sc_scale;
    int n;
    for (int k = 0; k < 8; k++)
      xfer(1'b1, 16'h8800, 3'h7, 2'b01, 1'b1, 3'(k), n);
  endtask

  // reset cut into a running transfer; the stored page must be forgotten
  task sc_reset;
    int n;
    @(negedge clk_sys);
    {xfer_addr, data_stretch_sel, xfer_req} = {16'h9900, 3'h5, 1'b1};
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b0;
    xfer_req = 1'b0;
    @(negedge clk_sys);
    chk("reset outputs", 17'h6, 17'({busy_q, done_q, ale_q, rd_n_q, wr_n_q, page_miss_q}));
    chk("reset stretch", 17'h0, 17'(stretch_cycles_q));
    chk("reset quarters", 17'h0, strobe_quarters_q);
    rst_n = 1'b1;
    page_ok = 1'b0;
    xfer(1'b0, 16'h9900, 3'h2, 2'b01, 1'b1, 3'b010, n);
  endtask

  initial
  begin
    {xfer_req, xfer_write, xfer_addr, data_stretch_sel, page_timing_sel} = '0;
    {page_mode_en, clock_multiplier_sel, clock_divide_sel} = 4'h2;
    {rst_n, page_ok, prev_hi, err_total, compares, cycles} = '0;
    repeat (6) @(negedge clk_sys);
    chk("idle strobes", 17'h3, 17'({rd_n_q, wr_n_q}));
    rst_n = 1'b1;
    sc_codes(2'b01);
    sc_codes(2'b10);
    sc_miss_hit();
    sc_forced();
    sc_scale();
    sc_reset();
    conclude();
  end
endmodule
